// *** lsm_pkg.sv ***
// package: opcodes, shift kinds, carriers and constants for the logic/shift/move datapath
// How it works
// - and, exclusive-or and or combine first source with second operand bit by bit.
// - bit clear ands first source with complement of second operand.
// - or-not ors first source with complement of second operand.
// - with flag update, logic ops, copy (except wide immediate) and copy-inverted set n,z; carry from shifter or immediate; v kept.
// - register shift amounts use only the low byte, 0 to 255.
// - immediate amounts: asr/lsr 1-32, lsl 0-31, ror 1-31.
// - rotate-extend shifts right by one with carry entering bit 31.
// - shifts write only the destination; shifted source stays unmodified.
// - with flag update shifts set n,z and carry to last bit out; amount 0 keeps carry, except rotate-extend.
// - leading zero count gives 32 for zero, 0 when bit 31 set; flags kept.
// - compare subtracts, discards difference, updates n,z,c,v.
// - compare-negative adds, discards sum, updates n,z,c,v.
// - copy writes second operand; wide immediate 0-65535 is zero-extended.
// - copy with register-shifted register acts like the shift operation, except that a pc destination branches and pc or sp raise illegal use.
// - copy-inverted writes the complement of the second operand.
// - copy to program counter clears bit 0 and branches there.
// - load-upper writes immediate to bits 31:16, keeps bits 15:0 and flags.
package lsm_pkg;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned WIDE_IMMEDIATE_W     = 16;
    localparam int unsigned AMOUNT_W    = 8;
    localparam int unsigned IMM_AMT_W   = 6;
    localparam int unsigned REG_IDX_W   = 4;
    localparam logic [3:0]  PC_INDEX    = 4'hF;
    localparam logic [3:0]  SP_INDEX    = 4'hD;
    localparam logic [31:0] RESULT_RST  = 32'h0000_0000;
    localparam logic [5:0]  MAX_SHIFT   = 6'h20;
    localparam logic [5:0]  CLZ_ALLZERO = 6'h20;
    localparam int unsigned OP_LATENCY  = 1;

    typedef enum logic [4:0] {
        conj_op,
        bitwise_disj_op,
        exclusive_disj_op,
        bit_clear_op,
        disj_not_op,
        arith_shift_right_op,
        logic_shift_left_op,
        logic_shift_right_op,
        rotate_right_op,
        rotate_extend_op,
        leading_zero_count_op,
        compare_sub_op,
        compare_add_op,
        copy_op,
        copy_inverted_op,
        load_upper_half_op
    } opcode_t;

    typedef enum logic [2:0] {
        shift_lsl,
        shift_lsr,
        shift_asr,
        shift_ror,
        shift_rrx
    } shift_kind_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_t;

    // flexible second operand as delivered by the decoder
    typedef struct packed {
        logic                  is_imm;
        logic [31:0]           imm_value;
        logic                  imm_carry_valid;
        logic                  imm_carry;
        shift_kind_t           kind;
        logic                  by_reg;
        logic [IMM_AMT_W-1:0]  imm_amount;
    } flexible_second_operand_t;

    typedef struct packed {
        logic                  valid;
        opcode_t               op;
        logic                  set_flags;
        logic                  wide_imm;
        logic [WIDE_IMMEDIATE_W-1:0]    wide_immediate;
        logic [REG_IDX_W-1:0]  dest_idx;
        flexible_second_operand_t             op2;
    } request_t;

    typedef struct packed {
        logic                  valid;
        logic                  write_en;
        logic [REG_IDX_W-1:0]  dest_idx;
        logic [31:0]           value;
        logic                  branch;
        logic [31:0]           branch_target;
    } result_t;

    typedef struct packed {
        logic        illegal;
        logic [31:0] result_value;
        logic        shift_carry;
    } dp_pipe_t;
endpackage

// *** lsm_shifter.sv ***
// barrel shifter: all shift kinds with carry-out of the last bit shifted
module lsm_shifter #(
    parameter int unsigned WIDTH = 32
) (
    // operand
    input  wire logic [WIDTH-1:0]          value,
    input  wire lsm_pkg::shift_kind_t      kind,
    input  wire logic [7:0]                amount,
    input  wire logic                      carry_in,
    // result
    output logic [WIDTH-1:0]               shifted,
    output logic                           carry_out
);
    if (WIDTH != 32) begin : g_width_check
        $error("lsm_shifter supports only 32-bit width");
    end

    logic [2*WIDTH:0]   wide;
    logic [4:0]         rot;

    always_comb begin
        wide      = '0;
        rot       = amount[4:0];
        shifted   = value;
        carry_out = carry_in;
        // amount 0 passes value and keeps carry, except rrx, which always shifts by one
        unique case (kind)
            lsm_pkg::shift_lsl: begin
                if (amount == 8'h00) begin
                    shifted   = value;
                end else if (amount < 8'h20) begin
                    wide      = {{(WIDTH+1){1'b0}}, value} << amount;
                    shifted   = wide[WIDTH-1:0];
                    carry_out = wide[WIDTH];
                end else if (amount == 8'h20) begin
                    shifted   = '0;
                    carry_out = value[0];
                end else begin
                    shifted   = '0;
                    carry_out = 1'b0;
                end
            end
            lsm_pkg::shift_lsr, lsm_pkg::shift_asr: begin
                if (amount == 8'h00) begin
                    shifted = value;
                end else if (amount <= 8'h20) begin
                    wide = {(kind == lsm_pkg::shift_asr) ? {WIDTH{value[WIDTH-1]}} : {WIDTH{1'b0}}, value, 1'b0}
                           >> amount;
                    shifted   = wide[WIDTH:1];
                    carry_out = wide[0];
                end else begin
                    shifted   = (kind == lsm_pkg::shift_asr) ? {WIDTH{value[WIDTH-1]}} : '0;
                    carry_out = (kind == lsm_pkg::shift_asr) ? value[WIDTH-1] : 1'b0;
                end
            end
            lsm_pkg::shift_ror: begin
                if (amount != 8'h00) begin
                    shifted   = (value >> rot) | (value << (6'(WIDTH) - {1'b0, rot}));
                    carry_out = shifted[WIDTH-1];
                end
            end
            lsm_pkg::shift_rrx: begin
                shifted   = {carry_in, value[WIDTH-1:1]};
                carry_out = value[0];
            end
            default: begin
                shifted   = value;
                carry_out = carry_in;
            end
        endcase
    end
endmodule

// *** lsm_clz.sv ***
// leading zero counter
module lsm_clz #(
    parameter int unsigned WIDTH = 32
) (
    // operand
    input  wire logic [WIDTH-1:0]          value,
    // count
    output logic [$clog2(WIDTH+1)-1:0]     count
);
    if (WIDTH < 2) begin : g_width_check
        $error("lsm_clz needs at least two bits");
    end

    logic found;

    always_comb begin
        found = 1'b0;
        count = ($clog2(WIDTH+1))'(WIDTH);
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (!found && value[i]) begin
                found = 1'b1;
                count = ($clog2(WIDTH+1))'(WIDTH - 1 - i);
            end
        end
    end
endmodule

// *** logic_shift_move_datapath.sv ***
// logic, shift, compare and move execution datapath with condition flags
module logic_shift_move_datapath (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst_n,
    // request from the decoder
    input  wire lsm_pkg::request_t   req,
    input  wire logic [31:0]         first_src_reg,
    input  wire logic [31:0]         shifted_src_reg,
    input  wire logic [31:0]         shift_amount_reg,
    input  wire logic [31:0]         dest_old_value,
    // result to the register file
    output lsm_pkg::result_t         result,
    // condition flags
    output lsm_pkg::flags_t          flags,
    output logic                     illegal_use
);
    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        lsm_pkg::result_t res;
        lsm_pkg::flags_t  flg;
        logic             illegal;
    } state_t;

    state_t st;
    state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // operand shifter

    logic [7:0]  shift_amount;
    logic [31:0] op2_value;
    logic        op2_carry;
    logic [31:0] shift_in;
    lsm_pkg::shift_kind_t shift_kind;
    logic [5:0]  clz_count;

    always_comb begin
        shift_kind = req.op2.kind;
        shift_in   = shifted_src_reg;
        if (req.op2.by_reg) begin
            shift_amount = shift_amount_reg[7:0];
        end else begin
            shift_amount = {2'b00, req.op2.imm_amount};
        end
        // standalone shift ops map onto the same shifter as copy forms
        unique case (req.op)
            lsm_pkg::arith_shift_right_op: shift_kind = lsm_pkg::shift_asr;
            lsm_pkg::logic_shift_left_op:  shift_kind = lsm_pkg::shift_lsl;
            lsm_pkg::logic_shift_right_op: shift_kind = lsm_pkg::shift_lsr;
            lsm_pkg::rotate_right_op:      shift_kind = lsm_pkg::shift_ror;
            lsm_pkg::rotate_extend_op:     shift_kind = lsm_pkg::shift_rrx;
            default:                       shift_kind = req.op2.kind;
        endcase
    end

    logic [31:0] shifter_out;
    logic        shifter_carry;

    lsm_shifter #(
        .WIDTH (lsm_pkg::DATA_W)
    ) u_shifter (
        .value     (shift_in),
        .kind      (shift_kind),
        .amount    (shift_amount),
        .carry_in  (st.flg.c),
        .shifted   (shifter_out),
        .carry_out (shifter_carry)
    );

    lsm_clz #(
        .WIDTH (lsm_pkg::DATA_W)
    ) u_clz (
        .value (shifted_src_reg),
        .count (clz_count)
    );

    always_comb begin
        if (req.op2.is_imm) begin
            op2_value = req.op2.imm_value;
            op2_carry = req.op2.imm_carry_valid ? req.op2.imm_carry : st.flg.c;
        end else begin
            op2_value = shifter_out;
            op2_carry = shifter_carry;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic for compares

    logic [32:0] sub_wide;
    logic [32:0] add_wide;
    logic        sub_ovf;
    logic        add_ovf;

    always_comb begin
        sub_wide = {1'b0, first_src_reg} + {1'b0, ~op2_value} + 33'h0_0000_0001;
        add_wide = {1'b0, first_src_reg} + {1'b0, op2_value};
        sub_ovf  = (first_src_reg[31] != op2_value[31]) && (sub_wide[31] != first_src_reg[31]);
        add_ovf  = (first_src_reg[31] == op2_value[31]) && (add_wide[31] != first_src_reg[31]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [31:0] value;
    logic        writes;
    logic        logic_flags;
    logic        special_reg;

    always_comb begin
        next_st           = st;
        next_st.res.valid = 1'b0;
        next_st.res.write_en = 1'b0;
        next_st.res.branch   = 1'b0;
        value       = lsm_pkg::RESULT_RST;
        writes      = 1'b1;
        logic_flags = 1'b0;
        special_reg = (req.dest_idx == lsm_pkg::PC_INDEX) || (req.dest_idx == lsm_pkg::SP_INDEX);
        unique case (req.op)
            lsm_pkg::conj_op: begin
                value       = first_src_reg & op2_value;
                logic_flags = 1'b1;
            end
            lsm_pkg::bitwise_disj_op: begin
                value       = first_src_reg | op2_value;
                logic_flags = 1'b1;
            end
            lsm_pkg::exclusive_disj_op: begin
                value       = first_src_reg ^ op2_value;
                logic_flags = 1'b1;
            end
            lsm_pkg::bit_clear_op: begin
                value       = first_src_reg & ~op2_value;
                logic_flags = 1'b1;
            end
            lsm_pkg::disj_not_op: begin
                value       = first_src_reg | ~op2_value;
                logic_flags = 1'b1;
            end
            lsm_pkg::arith_shift_right_op, lsm_pkg::logic_shift_left_op, lsm_pkg::logic_shift_right_op,
            lsm_pkg::rotate_right_op, lsm_pkg::rotate_extend_op: begin
                value       = shifter_out;
                logic_flags = 1'b1;
            end
            lsm_pkg::leading_zero_count_op: begin
                value = {26'h000_0000, clz_count};
            end
            lsm_pkg::compare_sub_op: begin
                writes = 1'b0;
            end
            lsm_pkg::compare_add_op: begin
                writes = 1'b0;
            end
            lsm_pkg::copy_op: begin
                if (req.wide_imm) begin
                    value = {16'h0000, req.wide_immediate};
                end else begin
                    value       = op2_value;
                    logic_flags = 1'b1;
                end
            end
            lsm_pkg::copy_inverted_op: begin
                value       = ~op2_value;
                logic_flags = 1'b1;
            end
            lsm_pkg::load_upper_half_op: begin
                value = {req.wide_immediate, dest_old_value[15:0]};
            end
            default: begin
                writes = 1'b0;
            end
        endcase

        if (req.valid) begin
            next_st.res.valid    = 1'b1;
            next_st.res.dest_idx = req.dest_idx;
            next_st.res.value    = value;
            next_st.illegal      = 1'b0;
            if (writes && req.op == lsm_pkg::copy_op && req.dest_idx == lsm_pkg::PC_INDEX) begin
                next_st.res.branch        = 1'b1;
                next_st.res.branch_target = {value[31:1], 1'b0};
                next_st.res.value         = {value[31:1], 1'b0};
            end else begin
                next_st.res.write_en = writes;
            end
            // flag the software misuse; the datapath still executes
            if (req.op == lsm_pkg::copy_op && special_reg && (req.set_flags || !(req.op2.is_imm == 1'b0
                && req.op2.kind == lsm_pkg::shift_lsl && !req.op2.by_reg && req.op2.imm_amount == 6'h00))) begin
                next_st.illegal = 1'b1;
            end
            if (req.op == lsm_pkg::load_upper_half_op && special_reg) begin
                next_st.illegal = 1'b1;
            end
            if (req.op == lsm_pkg::compare_sub_op) begin
                next_st.flg = '{n: sub_wide[31], z: (sub_wide[31:0] == 32'h0000_0000), c: sub_wide[32],
                                v: sub_ovf};
            end else if (req.op == lsm_pkg::compare_add_op) begin
                next_st.flg = '{n: add_wide[31], z: (add_wide[31:0] == 32'h0000_0000), c: add_wide[32],
                                v: add_ovf};
            end else if (logic_flags && req.set_flags) begin
                next_st.flg.n = value[31];
                next_st.flg.z = (value == 32'h0000_0000);
                next_st.flg.c = op2_carry;
            end
            // otherwise every flag holds its value
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign result      = st.res;
    assign flags       = st.flg;
    assign illegal_use = st.illegal;
endmodule

// *** lsm_dp_chk.sv ***
// checker: concurrent assertions on the datapath ports
module lsm_dp_chk (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // watched ports
    input wire lsm_pkg::request_t req,
    input wire logic [31:0]       first_src_reg,
    input wire logic [31:0]       shifted_src_reg,
    input wire logic [31:0]       shift_amount_reg,
    input wire logic [31:0]       dest_old_value,
    input wire lsm_pkg::result_t  result,
    input wire lsm_pkg::flags_t   flags,
    input wire logic              illegal_use
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_result_pulse: assert property (result.valid == $past(req.valid))
        else $error("result valid does not follow request");
    a_conj_value: assert property (req.valid && req.op == lsm_pkg::conj_op && req.op2.is_imm
        |=> result.value == ($past(first_src_reg) & $past(req.op2.imm_value))) else $error("and result wrong");
    a_clear_value: assert property (req.valid && req.op == lsm_pkg::bit_clear_op && req.op2.is_imm
        |=> result.value == ($past(first_src_reg) & ~$past(req.op2.imm_value))) else $error("bit clear result wrong");
    a_ornot_value: assert property (req.valid && req.op == lsm_pkg::disj_not_op && req.op2.is_imm
        |=> result.value == ($past(first_src_reg) | ~$past(req.op2.imm_value))) else $error("or-not result wrong");
    a_v_kept: assert property (req.valid && req.set_flags && (req.op inside {lsm_pkg::conj_op,
        lsm_pkg::bitwise_disj_op, lsm_pkg::exclusive_disj_op, lsm_pkg::bit_clear_op, lsm_pkg::disj_not_op,
        lsm_pkg::copy_op, lsm_pkg::copy_inverted_op}) |=> flags.v == $past(flags.v)) else $error("v changed");
    a_count_flags: assert property (req.valid && req.op == lsm_pkg::leading_zero_count_op
        |=> $stable(flags) && result.write_en) else $error("leading zero count touched flags");
    a_compare_nowrite: assert property (req.valid && (req.op inside {lsm_pkg::compare_sub_op,
        lsm_pkg::compare_add_op}) |=> result.valid && !result.write_en) else $error("compare wrote result");
    a_pc_branch: assert property (req.valid && req.op == lsm_pkg::copy_op && !req.op2.is_imm
        && !req.op2.by_reg && req.op2.imm_amount == 6'h00 && req.dest_idx == lsm_pkg::PC_INDEX
        && req.op2.kind == lsm_pkg::shift_lsl
        |=> result.branch && result.branch_target == ($past(shifted_src_reg) & 32'hFFFF_FFFE))
        else $error("copy to program counter did not branch");
    a_upper_half: assert property (req.valid && req.op == lsm_pkg::load_upper_half_op
        |=> result.value == {$past(req.wide_immediate), $past(dest_old_value[15:0])} && $stable(flags))
        else $error("load upper result wrong");
    a_flags_kept: assert property (req.valid && !req.set_flags && !(req.op inside {
        lsm_pkg::compare_sub_op, lsm_pkg::compare_add_op}) |=> $stable(flags)) else $error("flags changed");
endmodule
bind logic_shift_move_datapath lsm_dp_chk lsm_dp_chk_i (.clock(clock), .rst_n(rst_n), .req(req),
    .first_src_reg(first_src_reg), .shifted_src_reg(shifted_src_reg), .shift_amount_reg(shift_amount_reg),
    .dest_old_value(dest_old_value), .result(result), .flags(flags), .illegal_use(illegal_use));

// *** lsm_regfile_model.sv ***
// partner: register file that takes the datapath results
module lsm_regfile_model (
    // clock and reset
    input wire logic             clock,
    input wire logic             rst_n,
    // result from the datapath
    input wire lsm_pkg::result_t result
);
    logic [31:0] regs [16];
    logic [31:0] pc_value;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 32'h0000_0000;
            end
            pc_value <= 32'h0000_0000;
        end else begin
            if (result.valid && result.write_en) begin
                regs[result.dest_idx] <= result.value;
            end
            if (result.valid && result.branch) begin
                pc_value <= result.branch_target;
            end
        end
    end
endmodule

// *** logic_shift_move_datapath_tb.sv ***
// testbench: directed scenarios for the logic, shift and move datapath
module logic_shift_move_datapath_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    lsm_pkg::request_t req = '0;
    logic [31:0]       first_src_reg = 32'h0;
    logic [31:0]       shifted_src_reg = 32'h0;
    logic [31:0]       shift_amount_reg = 32'h0;
    logic [31:0]       dest_old_value = 32'h0;
    lsm_pkg::result_t  result;
    lsm_pkg::flags_t   flags;
    logic              illegal_use;
    lsm_pkg::flags_t   ef = '0;
    int                errors = 0;
    int                checks_done = 0;
    ////////////////////////////////////////////////////////////////////////////////
    logic_shift_move_datapath logic_shift_move_datapath_i (.clock(clock), .rst_n(rst_n), .req(req),
        .first_src_reg(first_src_reg), .shifted_src_reg(shifted_src_reg), .shift_amount_reg(shift_amount_reg),
        .dest_old_value(dest_old_value), .result(result), .flags(flags), .illegal_use(illegal_use));
    lsm_regfile_model lsm_regfile_model_i (.clock(clock), .rst_n(rst_n), .result(result));
    always #2.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic lsm_pkg::request_t mk(input lsm_pkg::opcode_t op, input logic sf, input logic imm,
                                             input logic [31:0] x, input logic br, input logic [5:0] amt);
        lsm_pkg::request_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.set_flags = sf;
        r.dest_idx = 4'h3;
        r.op2.is_imm = imm;
        r.op2.imm_value = x;
        r.op2.by_reg = br;
        r.op2.imm_amount = amt;
        return r;
    endfunction
    function automatic lsm_pkg::flags_t nz(input logic [31:0] x, input logic c);
        return '{n: x[31], z: (x == 32'h0), c: c, v: ef.v};
    endfunction
    task automatic do_op(input lsm_pkg::request_t r, input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] s, input logic [31:0] d);
        @(negedge clock);
        req = r;
        first_src_reg = a;
        shifted_src_reg = m;
        shift_amount_reg = s;
        dest_old_value = d;
        @(negedge clock);
        req.valid = 1'b0;
    endtask
    task automatic expect_res(input logic [31:0] x, input logic we);
        check({31'h0, result.valid}, 32'h1);
        check({31'h0, result.write_en}, {31'h0, we});
        if (we) begin
            check(result.value, x);
        end
        check({28'h0, flags}, {28'h0, ef});
    endtask
    task automatic sh(input lsm_pkg::opcode_t op, input logic br, input logic [5:0] amt, input logic [31:0] s,
                      input logic [31:0] x, input logic c);
        do_op(mk(op, 1'b1, 1'b0, 32'h0, br, amt), 32'h0, 32'h8000_0003, s, 32'h0);
        ef = nz(x, c);
        expect_res(x, 1'b1);
        check({28'h0, result.dest_idx}, 32'h3);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_compare;
        do_op(mk(lsm_pkg::compare_sub_op, 1'b1, 1'b1, 32'hFFFF_FFFF, 1'b0, 6'h0), 32'h7FFF_FFFF, 0, 0, 0);
        ef = 4'h9;
        expect_res(32'h0, 1'b0);
        do_op(mk(lsm_pkg::compare_add_op, 1'b1, 1'b1, 32'hFFFF_FFFF, 1'b0, 6'h0), 32'h0000_0001, 0, 0, 0);
        ef = 4'h6;
        expect_res(32'h0, 1'b0);
        do_op(mk(lsm_pkg::compare_add_op, 1'b1, 1'b1, 32'h0000_0001, 1'b0, 6'h0), 32'h7FFF_FFFF, 0, 0, 0);
        ef = 4'h9;
        expect_res(32'h0, 1'b0);
    endtask
    task automatic t_logic;
        lsm_pkg::opcode_t ops [5] = '{lsm_pkg::conj_op, lsm_pkg::bitwise_disj_op, lsm_pkg::exclusive_disj_op,
                                      lsm_pkg::bit_clear_op, lsm_pkg::disj_not_op};
        logic [31:0]      exp [5] = '{32'hF000_1200, 32'hFFF0_FF34, 32'h0FF0_ED34, 32'h00F0_0034, 32'hF0FF_12FF};
        for (int i = 0; i < 5; i++) begin
            do_op(mk(ops[i], ~i[0], 1'b1, 32'hFF00_FF00, 1'b0, 6'h0), 32'hF0F0_1234, 0, 0, 0);
            if (!i[0]) begin
                ef = nz(exp[i], ef.c);
            end
            expect_res(exp[i], 1'b1);
        end
    endtask
    task automatic t_shift;
        sh(lsm_pkg::logic_shift_right_op, 1'b0, 6'h20, 32'h0, 32'h0, 1'b1);
        sh(lsm_pkg::logic_shift_left_op, 1'b0, 6'h00, 32'h0, 32'h8000_0003, 1'b1);
        sh(lsm_pkg::rotate_right_op, 1'b0, 6'h04, 32'h0, 32'h3800_0000, 1'b0);
        sh(lsm_pkg::rotate_extend_op, 1'b0, 6'h00, 32'h0, 32'h4000_0001, 1'b1);
        sh(lsm_pkg::logic_shift_left_op, 1'b1, 6'h00, 32'hFFFF_FF21, 32'h0, 1'b0);
        sh(lsm_pkg::arith_shift_right_op, 1'b0, 6'h20, 32'h0, 32'hFFFF_FFFF, 1'b1);
        sh(lsm_pkg::rotate_extend_op, 1'b0, 6'h00, 32'h0, 32'hC000_0001, 1'b1);
    endtask
    task automatic t_move;
        lsm_pkg::request_t r;
        r = mk(lsm_pkg::copy_op, 1'b0, 1'b1, 32'h0, 1'b0, 6'h0);
        r.wide_imm = 1'b1;
        r.wide_immediate = 16'hFFFF;
        do_op(r, 0, 0, 0, 0);
        expect_res(32'h0000_FFFF, 1'b1);
        r = mk(lsm_pkg::copy_inverted_op, 1'b1, 1'b1, 32'h0000_000F, 1'b0, 6'h0);
        r.op2.imm_carry_valid = 1'b1;
        do_op(r, 0, 0, 0, 0);
        ef = nz(32'hFFFF_FFF0, 1'b0);
        expect_res(32'hFFFF_FFF0, 1'b1);
        r = mk(lsm_pkg::copy_op, 1'b1, 1'b0, 32'h0, 1'b1, 6'h0);
        r.op2.kind = lsm_pkg::shift_lsr;
        do_op(r, 0, 32'h8000_0003, 32'h0000_0101, 0);
        ef = nz(32'h4000_0001, 1'b1);
        expect_res(32'h4000_0001, 1'b1);
        r = mk(lsm_pkg::copy_op, 1'b0, 1'b0, 32'h0, 1'b0, 6'h0);
        r.dest_idx = lsm_pkg::PC_INDEX;
        do_op(r, 0, 32'h2000_0101, 0, 0);
        expect_res(32'h0, 1'b0);
        check({31'h0, result.branch}, 32'h1);
        check(result.branch_target, 32'h2000_0100);
        check({31'h0, illegal_use}, 32'h0);
        @(negedge clock);
        check(lsm_regfile_model_i.pc_value, 32'h2000_0100);
        r = mk(lsm_pkg::load_upper_half_op, 1'b0, 1'b1, 32'h0, 1'b0, 6'h0);
        r.wide_immediate = 16'hABCD;
        do_op(r, 0, 0, 0, 32'h1234_5678);
        expect_res(32'hABCD_5678, 1'b1);
        @(negedge clock);
        check(lsm_regfile_model_i.regs[3], 32'hABCD_5678);
        r = mk(lsm_pkg::copy_op, 1'b1, 1'b1, 32'h0000_0005, 1'b0, 6'h0);
        r.dest_idx = lsm_pkg::SP_INDEX;
        do_op(r, 0, 0, 0, 0);
        ef = nz(32'h0000_0005, ef.c);
        check({31'h0, illegal_use}, 32'h1);
        r = mk(lsm_pkg::load_upper_half_op, 1'b0, 1'b1, 32'h0, 1'b0, 6'h0);
        r.dest_idx = lsm_pkg::PC_INDEX;
        do_op(r, 0, 0, 0, 0);
        check({31'h0, illegal_use}, 32'h1);
        check({28'h0, flags}, {28'h0, ef});
    endtask
    task automatic t_count;
        logic [31:0] src [3] = '{32'h0000_0000, 32'h8000_0000, 32'h0001_0000};
        logic [31:0] exp [3] = '{32'h0000_0020, 32'h0000_0000, 32'h0000_000F};
        for (int i = 0; i < 3; i++) begin
            do_op(mk(lsm_pkg::leading_zero_count_op, 1'b1, 1'b0, 32'h0, 1'b0, 6'h0), 0, src[i], 0, 0);
            expect_res(exp[i], 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 5);
        errors++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        check({28'h0, flags}, 32'h0);
        check(result.value, 32'h0);
        t_compare();
        $display("compare test done");
        t_logic();
        $display("logic test done");
        t_shift();
        $display("shift test done");
        t_move();
        $display("move test done");
        t_count();
        $display("count test done");
        final_report();
    end
endmodule
